// ==== verilog/tocp_top.sv ====
// Contract
// [RULE_01] Counter equal to compare value sets, clears or toggles channel pin.
// [RULE_02] Compare match raises channel interrupt when channel interrupt enabled.
// [RULE_03] Unbuffered compare write replaces value for the next comparisons.
// [RULE_04] Only exact equality matches; passed values miss this period.
// [RULE_05] Software writes smaller unbuffered values in the compare handler.
// [RULE_06] Software writes larger unbuffered values in the overflow handler.
// [RULE_07] Overflow interrupt at end of each period.
// [RULE_08] Buffered bit in channel 0 control links channels onto pin 0.
// [RULE_09] Channel 0 controls first; channel 1 takes over at next overflow.
// [RULE_10] Each later overflow selects the most recently written channel value.
// [RULE_11] Linked: channel 0 control governs, channel 1 control ignored.
// [RULE_12] Linked: channel 1 pin released to general-purpose use.
// [RULE_13] Software never writes the active buffered register.
// [RULE_14] Toggle-on-overflow toggles pin when counter reaches modulo.
// [RULE_15] Software picks clear for high pulses, set for low pulses.
// [RULE_16] Undivided prescale with modulo 255 gives 256-clock period.
// [RULE_17] Compare 128 in 256-step period gives half duty.
// [RULE_18] Software never uses toggle-on-compare for PWM.
// [RULE_19] Compare match sets channel event flag.
// [RULE_20] Overflow flag set when counter reaches modulo.
// [RULE_21] Mode 01 unbuffered, mode 10 buffered.
// [RULE_22] Action 10 clears pin, 11 sets pin on compare.
// [RULE_23] Counter counts up per tick, wraps to zero after modulo.
`timescale 1ns/1ps
`default_nettype none
module tocp_top (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [4:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic OVF_IRQ_O,
    output logic CH0_IRQ_O,
    output logic CH1_IRQ_O,
    output logic CH0_PIN_O,
    output logic CH0_PIN_OE_O,
    output logic CH1_PIN_O,
    output logic CH1_PIN_OE_O
);
    logic [7:0] ctrl_r;
    logic [15:0] mod_r;
    logic [15:0] cnt_r;
    logic [7:0] ch0ctl_r;
    logic [7:0] ch1ctl_r;
    logic [15:0] ch0val_r;
    logic [15:0] ch1val_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic sel1_r;
    logic pend1_r;
    logic tof_armed_r;
    logic ch0_armed_r;
    logic ch1_armed_r;
    logic ovf_irq_r;
    logic ch0_irq_r;
    logic ch1_irq_r;
    logic pin0_r;
    logic pin1_r;
    logic oe0_r;
    logic oe1_r;

    logic req;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic wr_mod;
    logic wr_ch0ctl;
    logic wr_ch1ctl;
    logic wr_ch0val;
    logic wr_ch1val;
    logic rd_ctrl;
    logic rd_ch0ctl;
    logic rd_ch1ctl;
    logic tick;
    logic at_mod;
    logic ovf;
    logic linked;
    logic [15:0] cmp0;
    logic match0;
    logic match1;
    logic ch0_en;
    logic ch1_en;
    logic ch0_pin;
    logic ch1_pin;
    logic [15:0] cnt_nxt;
    logic [15:0] cnt_step;
    logic [7:0] ctrl_nxt;
    logic [7:0] ch0ctl_nxt;
    logic [7:0] ch1ctl_nxt;
    logic [31:0] rdata;
    logic sel1_nxt;
    logic pend1_nxt;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic is_out_mode(input logic [7:0] c);
        is_out_mode = (c[tocp_pkg::CH_MODE_LSB +: 2] == tocp_pkg::MODE_UNBUF) ||
                      (c[tocp_pkg::CH_MODE_LSB +: 2] == tocp_pkg::MODE_BUF); // [RULE_21]
    endfunction

    // Bus decode; single-cycle ack, one wait state for registered data
    assign req = CYC_I && STB_I && !ack_r;
    assign wr = req && WE_I;
    assign rd = req && !WE_I;
    assign wr_ctrl = wr && (ADR_I == tocp_pkg::ADDR_CTRL) && SEL_I[0];
    assign wr_mod = wr && (ADR_I == tocp_pkg::ADDR_MOD);
    assign wr_ch0ctl = wr && (ADR_I == tocp_pkg::ADDR_CH0CTL) && SEL_I[0];
    assign wr_ch1ctl = wr && (ADR_I == tocp_pkg::ADDR_CH1CTL) && SEL_I[0];
    assign wr_ch0val = wr && (ADR_I == tocp_pkg::ADDR_CH0VAL) && (SEL_I[1:0] != 2'h0);
    assign wr_ch1val = wr && (ADR_I == tocp_pkg::ADDR_CH1VAL) && (SEL_I[1:0] != 2'h0);
    assign rd_ctrl = rd && (ADR_I == tocp_pkg::ADDR_CTRL);
    assign rd_ch0ctl = rd && (ADR_I == tocp_pkg::ADDR_CH0CTL);
    assign rd_ch1ctl = rd && (ADR_I == tocp_pkg::ADDR_CH1CTL);

    tocp_prescaler u_ps (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .clr_i(wr_ctrl && DAT_I[tocp_pkg::CTRL_TRST]),
        .run_i(!ctrl_r[tocp_pkg::CTRL_STOP]),
        .sel_i(ctrl_r[tocp_pkg::CTRL_PS_LSB +: 3] > tocp_pkg::PS_MAX ? tocp_pkg::PS_MAX :
               ctrl_r[tocp_pkg::CTRL_PS_LSB +: 3]),
        .tick_o(tick)
    );

    assign at_mod = (cnt_r == mod_r);
    assign ovf = tick && at_mod; // [RULE_20] [RULE_16]
    // Value the count steps onto at the next tick
    assign cnt_step = at_mod ? 16'h0000 : 16'(cnt_r + 16'h0001);
    assign cnt_nxt = (wr_ctrl && DAT_I[tocp_pkg::CTRL_TRST]) ? 16'h0000 :
                     tick ? cnt_step : cnt_r; // [RULE_23]

    // Link: channel 0 mode field top bit wins over its low bit
    assign linked = ch0ctl_r[tocp_pkg::CH_MODE_LSB + 1]; // [RULE_08] [RULE_11]
    assign cmp0 = (linked && sel1_r) ? ch1val_r : ch0val_r; // [RULE_09]
    // Exact equality only; a value already passed waits a whole period
    // Fires as the count steps onto the value, so 128 of 256 is exactly half
    assign match0 = tick && (cnt_step == cmp0); // [RULE_04] [RULE_03] [RULE_17]
    assign match1 = tick && !linked && (cnt_step == ch1val_r);
    assign ch0_en = is_out_mode(ch0ctl_r);
    assign ch1_en = !linked && is_out_mode(ch1ctl_r); // [RULE_12]

    tocp_channel u_ch0 (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .tick_i(tick),
        .match_i(cnt_step == cmp0),
        .ovf_i(at_mod),
        .active_i(ch0_en),
        .act_i(ch0ctl_r[tocp_pkg::CH_ACT_LSB +: 2]), // [RULE_22]
        .tov_i(ch0ctl_r[tocp_pkg::CH_TOV]),
        .pin_o(ch0_pin)
    );

    tocp_channel u_ch1 (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .tick_i(tick),
        .match_i(cnt_step == ch1val_r),
        .ovf_i(at_mod),
        .active_i(ch1_en),
        .act_i(ch1ctl_r[tocp_pkg::CH_ACT_LSB +: 2]),
        .tov_i(ch1ctl_r[tocp_pkg::CH_TOV]),
        .pin_o(ch1_pin)
    );

    // Last written pair takes over only at overflow
    assign pend1_nxt = wr_ch1val ? 1'b1 : wr_ch0val ? 1'b0 : pend1_r;
    assign sel1_nxt = !linked ? 1'b0 : ovf ? pend1_nxt : sel1_r; // [RULE_10] [RULE_09]

    // Flags: set wins over clear; clear needs read-while-set first
    assign ctrl_nxt = {
        ovf | (ctrl_r[tocp_pkg::CTRL_TOF] &
               ~(wr_ctrl && tof_armed_r && !DAT_I[tocp_pkg::CTRL_TOF])), // [RULE_20]
        wr_ctrl ? DAT_I[6] : ctrl_r[6],
        1'b0,
        wr_ctrl ? DAT_I[4] : ctrl_r[4],
        1'b0,
        wr_ctrl ? DAT_I[2:0] : ctrl_r[2:0]
    };
    assign ch0ctl_nxt = {
        (match0 && ch0_en) | (ch0ctl_r[7] &
               ~(wr_ch0ctl && ch0_armed_r && !DAT_I[tocp_pkg::CH_FLAG])), // [RULE_19]
        wr_ch0ctl ? DAT_I[6:0] : ch0ctl_r[6:0]
    };
    assign ch1ctl_nxt = {
        (match1 && ch1_en) | (ch1ctl_r[7] &
               ~(wr_ch1ctl && ch1_armed_r && !DAT_I[tocp_pkg::CH_FLAG])),
        wr_ch1ctl ? DAT_I[6:0] : ch1ctl_r[6:0]
    };

    assign rdata = (ADR_I == tocp_pkg::ADDR_CTRL) ? {24'h0, ctrl_r} :
                   (ADR_I == tocp_pkg::ADDR_MOD) ? {16'h0, mod_r} :
                   (ADR_I == tocp_pkg::ADDR_CNT) ? {16'h0, cnt_r} :
                   (ADR_I == tocp_pkg::ADDR_CH0CTL) ? {24'h0, ch0ctl_r} :
                   (ADR_I == tocp_pkg::ADDR_CH1CTL) ? {24'h0, ch1ctl_r} :
                   (ADR_I == tocp_pkg::ADDR_CH0VAL) ? {16'h0, ch0val_r} :
                   (ADR_I == tocp_pkg::ADDR_CH1VAL) ? {16'h0, ch1val_r} : 32'h0;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_r <= tocp_pkg::CTRL_RESET;
            mod_r <= tocp_pkg::MOD_RESET;
            cnt_r <= 16'h0000;
            ch0ctl_r <= tocp_pkg::CH_RESET;
            ch1ctl_r <= tocp_pkg::CH_RESET;
            ch0val_r <= tocp_pkg::VAL_RESET;
            ch1val_r <= tocp_pkg::VAL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            ch0ctl_r <= ch0ctl_nxt;
            ch1ctl_r <= ch1ctl_nxt;
            if (wr_mod) begin
                mod_r <= merge16(mod_r, DAT_I, SEL_I);
            end
            if (wr_ch0val) begin
                ch0val_r <= merge16(ch0val_r, DAT_I, SEL_I); // [RULE_03]
            end
            if (wr_ch1val) begin
                ch1val_r <= merge16(ch1val_r, DAT_I, SEL_I);
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sel1_r <= 1'b0;
            pend1_r <= 1'b0;
            tof_armed_r <= 1'b0;
            ch0_armed_r <= 1'b0;
            ch1_armed_r <= 1'b0;
        end else begin
            sel1_r <= sel1_nxt;
            pend1_r <= pend1_nxt;
            tof_armed_r <= rd_ctrl ? ctrl_r[tocp_pkg::CTRL_TOF] : tof_armed_r && !wr_ctrl;
            ch0_armed_r <= rd_ch0ctl ? ch0ctl_r[7] : ch0_armed_r && !wr_ch0ctl;
            ch1_armed_r <= rd_ch1ctl ? ch1ctl_r[7] : ch1_armed_r && !wr_ch1ctl;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            ovf_irq_r <= 1'b0;
            ch0_irq_r <= 1'b0;
            ch1_irq_r <= 1'b0;
            pin0_r <= 1'b0;
            pin1_r <= 1'b0;
            oe0_r <= 1'b0;
            oe1_r <= 1'b0;
        end else begin
            ack_r <= req;
            dat_r <= rd ? rdata : 32'h0;
            ovf_irq_r <= ctrl_r[tocp_pkg::CTRL_TOF] && ctrl_r[tocp_pkg::CTRL_TOIE]; // [RULE_07]
            ch0_irq_r <= ch0ctl_r[7] && ch0ctl_r[tocp_pkg::CH_IE]; // [RULE_02]
            ch1_irq_r <= ch1ctl_r[7] && ch1ctl_r[tocp_pkg::CH_IE] && !linked;
            pin0_r <= ch0_pin;
            pin1_r <= ch1_pin;
            oe0_r <= ch0_en;
            oe1_r <= ch1_en; // [RULE_12]
        end
    end

    assign DAT_O = dat_r;
    assign ACK_O = ack_r;
    assign OVF_IRQ_O = ovf_irq_r;
    assign CH0_IRQ_O = ch0_irq_r;
    assign CH1_IRQ_O = ch1_irq_r;
    assign CH0_PIN_O = pin0_r;
    assign CH0_PIN_OE_O = oe0_r;
    assign CH1_PIN_O = pin1_r;
    assign CH1_PIN_OE_O = oe1_r;

    // Checks
    property p_ovf_flag;
        @(posedge CLK_I) disable iff (RST_I) ovf |=> ctrl_r[tocp_pkg::CTRL_TOF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // [RULE_20]
    property p_wrap;
        @(posedge CLK_I) disable iff (RST_I) (ovf && !wr_ctrl) |=> (cnt_r == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // [RULE_23]
    property p_ch_flag;
        @(posedge CLK_I) disable iff (RST_I) (match0 && ch0_en) |=> ch0ctl_r[7];
    endproperty
    a_ch_flag: assert property (p_ch_flag) else $error("channel flag not set"); // [RULE_19]
    property p_irq0;
        @(posedge CLK_I) disable iff (RST_I)
            (ch0ctl_r[7] && ch0ctl_r[tocp_pkg::CH_IE]) |=> CH0_IRQ_O;
    endproperty
    a_irq0: assert property (p_irq0) else $error("channel irq missing"); // [RULE_02]
    property p_ovf_irq;
        @(posedge CLK_I) disable iff (RST_I)
            (ovf && ctrl_r[tocp_pkg::CTRL_TOIE] && !wr_ctrl) |=> ##1 OVF_IRQ_O;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing"); // [RULE_07]
    property p_set_act;
        @(posedge CLK_I) disable iff (RST_I)
            (match0 && ch0_en && !at_mod && ch0ctl_r[1:0] == tocp_pkg::ACT_SET) |=> ##1 CH0_PIN_O;
    endproperty
    a_set_act: assert property (p_set_act) else $error("set on compare failed"); // [RULE_22]
    property p_tov;
        @(posedge CLK_I) disable iff (RST_I)
            (ovf && ch0_en && ch0ctl_r[tocp_pkg::CH_TOV]) |=> ##1 (CH0_PIN_O != $past(CH0_PIN_O));
    endproperty
    a_tov: assert property (p_tov) else $error("overflow toggle missing"); // [RULE_14]
    property p_release;
        @(posedge CLK_I) disable iff (RST_I) linked |=> !CH1_PIN_OE_O;
    endproperty
    a_release: assert property (p_release) else $error("pin 1 not released"); // [RULE_12]
    property p_switch;
        @(posedge CLK_I) disable iff (RST_I) (!ovf && linked) |=> (sel1_r == $past(sel1_r));
    endproperty
    a_switch: assert property (p_switch) else $error("buffer switched off overflow"); // [RULE_09]
    property p_clear_act;
        @(posedge CLK_I) disable iff (RST_I)
            (match0 && ch0_en && !at_mod && ch0ctl_r[1:0] == tocp_pkg::ACT_CLEAR)
                |=> ##1 !CH0_PIN_O;
    endproperty
    a_clear_act: assert property (p_clear_act) else $error("clear action failed"); // [RULE_22]
    property p_ch1_quiet;
        @(posedge CLK_I) disable iff (RST_I) linked |=> !CH1_IRQ_O;
    endproperty
    a_ch1_quiet: assert property (p_ch1_quiet) else $error("ch1 irq linked"); // [RULE_11]
    property p_mode_off;
        @(posedge CLK_I) disable iff (RST_I) !is_out_mode(ch0ctl_r) |=> !CH0_PIN_OE_O;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("pin 0 driven"); // [RULE_21]
    c_ovf: cover property (@(posedge CLK_I) disable iff (RST_I) ovf);
    c_match: cover property (@(posedge CLK_I) disable iff (RST_I) match0 && ch0_en);
    c_link_sw: cover property (@(posedge CLK_I) disable iff (RST_I) linked && ovf && pend1_r);
    c_prescaled: cover property (@(posedge CLK_I) disable iff (RST_I)
        !tick && !ctrl_r[tocp_pkg::CTRL_STOP]);
endmodule
`default_nettype wire

// ==== verilog/tocp_pkg.sv ====
`default_nettype none
package tocp_pkg;
    // Wishbone word offsets (byte addresses)
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_MOD = 5'h04;
    localparam logic [4:0] ADDR_CNT = 5'h08;
    localparam logic [4:0] ADDR_CH0CTL = 5'h0C;
    localparam logic [4:0] ADDR_CH1CTL = 5'h10;
    localparam logic [4:0] ADDR_CH0VAL = 5'h14;
    localparam logic [4:0] ADDR_CH1VAL = 5'h18;
    // Timer control fields
    localparam int CTRL_PS_LSB = 0;
    localparam int CTRL_TOIE = 4;
    localparam int CTRL_TRST = 5;
    localparam int CTRL_STOP = 6;
    localparam int CTRL_TOF = 7;
    // Channel control fields
    localparam int CH_ACT_LSB = 0;
    localparam int CH_TOV = 2;
    localparam int CH_MODE_LSB = 4;
    localparam int CH_IE = 6;
    localparam int CH_FLAG = 7;
    localparam logic [1:0] MODE_UNBUF = 2'h1;
    localparam logic [1:0] MODE_BUF = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // Reset values
    localparam logic [15:0] MOD_RESET = 16'hFFFF;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] CH_RESET = 8'h00;
    localparam logic [2:0] PS_MAX = 3'h6;
endpackage
`default_nettype wire

// ==== verilog/tocp_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tocp_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);
    logic [5:0] div_r;
    logic [6:0] div_ext;
    logic [6:0] sel_mask;
    assign div_ext = {1'b0, div_r} + 7'h01;
    // Divide by 2**sel; sel 0 ticks every bus clock
    assign sel_mask = 7'(({1'b0, 6'h3F}) >> (3'h6 - sel_i));
    assign tick_o = run_i && ((div_r & sel_mask[5:0]) == sel_mask[5:0]);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= 6'h00;
        end else if (clr_i) begin
            div_r <= 6'h00;
        end else if (run_i) begin
            div_r <= div_ext[5:0];
        end
    end
endmodule
`default_nettype wire

// ==== verilog/tocp_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module tocp_channel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic match_i,
    input wire logic ovf_i,
    input wire logic active_i,
    input wire logic [1:0] act_i,
    input wire logic tov_i,
    output logic pin_o
);
    logic pin_r;
    logic pin_nxt;
    logic pin_cmp;
    // Overflow toggle first; a compare action on the same tick is dropped
    assign pin_cmp = (act_i == tocp_pkg::ACT_SET) ? 1'b1 :
                     (act_i == tocp_pkg::ACT_CLEAR) ? 1'b0 :
                     (act_i == tocp_pkg::ACT_TOGGLE) ? ~pin_r : pin_r;
    assign pin_nxt = (tick_i && ovf_i && tov_i && active_i) ? ~pin_r :
                     (tick_i && match_i && active_i) ? pin_cmp : pin_r; // [RULE_01] [RULE_14]
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end
    assign pin_o = pin_r;
endmodule
`default_nettype wire

// ==== verification/tocp_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic CLK_I, RST_I, CYC_I, STB_I, WE_I, ACK_O;
    logic [4:0] ADR_I;
    logic [3:0] SEL_I;
    logic [31:0] DAT_I, DAT_O, rd;
    logic OVF_IRQ_O, CH0_IRQ_O, CH1_IRQ_O, CH0_PIN_O, CH0_PIN_OE_O, CH1_PIN_O, CH1_PIN_OE_O;
    int fails, tests_run, hi, lo, n, k;
    logic prev;
    logic [1:0] acts [3];

    tocp_top i_dut (
        .CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
        .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .OVF_IRQ_O(OVF_IRQ_O), .CH0_IRQ_O(CH0_IRQ_O), .CH1_IRQ_O(CH1_IRQ_O),
        .CH0_PIN_O(CH0_PIN_O), .CH0_PIN_OE_O(CH0_PIN_OE_O),
        .CH1_PIN_O(CH1_PIN_O), .CH1_PIN_OE_O(CH1_PIN_OE_O)
    );

    initial begin
        CLK_I = 1'b0;
        forever #12.5 CLK_I = ~CLK_I;
    end

    task results;
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled at a rising edge
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        int w;
        @(posedge CLK_I);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= a;
        DAT_I <= d;
        w = 0;
        do begin
            @(posedge CLK_I);
            w++;
        end while (ACK_O !== 1'b1 && w < 50);
        rd = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I <= 1'b0;
        if (w >= 50) begin
            fails++;
            $display("unexpected ack expected 1 seen timeout");
            results();
        end
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    function automatic logic [31:0] chc(input logic [1:0] mode, input logic tov,
                                       input logic [1:0] act, input logic ie);
        chc = (32'(act) << tocp_pkg::CH_ACT_LSB) | (32'(tov) << tocp_pkg::CH_TOV)
            | (32'(mode) << tocp_pkg::CH_MODE_LSB) | (32'(ie) << tocp_pkg::CH_IE);
    endfunction

    // sel 0 watches the channel 0 pin, sel 1 its interrupt
    task automatic wait_for(input int sel, input logic v);
        int w;
        w = 0;
        while (((sel == 0) ? CH0_PIN_O : CH0_IRQ_O) !== v && w < 2000) begin
            @(posedge CLK_I);
            w++;
        end
        if (w >= 2000) begin
            fails++;
            $display("unexpected wait_%0d expected %b seen timeout", sel, v);
            results();
        end
    endtask

    // One whole pulse: high cycles from a rising edge, then low cycles to the next
    task automatic pulse(output int h, output int l);
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
        h = 0;
        l = 0;
        while (CH0_PIN_O === 1'b1 && h < 2000) begin
            @(posedge CLK_I);
            h++;
        end
        while (CH0_PIN_O === 1'b0 && l < 2000) begin
            @(posedge CLK_I);
            l++;
        end
        if (h >= 2000 || l >= 2000) begin
            fails++;
            $display("unexpected pulse expected edge seen timeout");
            results();
        end
    endtask

    // Stop and clear the counter so each scenario starts from count zero
    task halt;
        wr(tocp_pkg::ADDR_CTRL, (32'h1 << tocp_pkg::CTRL_STOP) | (32'h1 << tocp_pkg::CTRL_TRST));
    endtask

    task start;
        wr(tocp_pkg::ADDR_CTRL, 32'h1 << tocp_pkg::CTRL_TOIE);
    endtask

    initial begin
        RST_I = 1'b1;
        CYC_I = 1'b0;
        STB_I = 1'b0;
        WE_I = 1'b0;
        ADR_I = 5'h00;
        SEL_I = 4'hF;
        DAT_I = 32'h0000_0000;
        fails = 0;
        tests_run = 0;
        acts = '{tocp_pkg::ACT_SET, tocp_pkg::ACT_CLEAR, tocp_pkg::ACT_TOGGLE};
        repeat (5) @(posedge CLK_I);
        RST_I <= 1'b0;
        wb(1'b0, tocp_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl_reset", {24'h0, tocp_pkg::CTRL_RESET}, rd);
        wb(1'b0, tocp_pkg::ADDR_MOD, 32'h0);
        chk("mod_reset", {16'h0, tocp_pkg::MOD_RESET}, rd);
        wb(1'b0, tocp_pkg::ADDR_CH0CTL, 32'h0);
        chk("ch0ctl_reset", {24'h0, tocp_pkg::CH_RESET}, rd);
        wb(1'b0, tocp_pkg::ADDR_CH0VAL, 32'h0);
        chk("ch0val_reset", {16'h0, tocp_pkg::VAL_RESET}, rd);
        wr(5'h1C, 32'hFFFF_FFFF);
        wb(1'b0, 5'h1C, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("outs_reset", 32'h0, {CH0_PIN_OE_O, CH1_PIN_OE_O, CH0_PIN_O, OVF_IRQ_O});
        // Unbuffered PWM, 8-bit period, half duty
        halt();
        wr(tocp_pkg::ADDR_MOD, 32'h0000_00FF);
        wr(tocp_pkg::ADDR_CH0VAL, 32'h0000_0080);
        wr(tocp_pkg::ADDR_CH0CTL, chc(tocp_pkg::MODE_UNBUF, 1'b1, tocp_pkg::ACT_CLEAR, 1'b1));
        start();
        chk("ch0_oe", 32'h1, 32'(CH0_PIN_OE_O));
        pulse(hi, lo);
        chk("pwm_high", 32'd128, 32'(hi));
        chk("pwm_period", 32'd256, 32'(hi + lo));
        repeat (3) @(posedge CLK_I);
        chk("ovf_irq", 32'h1, 32'(OVF_IRQ_O));
        chk("ch0_irq", 32'h1, 32'(CH0_IRQ_O));
        wb(1'b0, tocp_pkg::ADDR_CTRL, 32'h0);
        chk("ovf_flag", 32'h1, 32'(rd[tocp_pkg::CTRL_TOF]));
        start();
        repeat (2) @(posedge CLK_I);
        chk("ovf_irq_clr", 32'h0, 32'(OVF_IRQ_O));
        wb(1'b0, tocp_pkg::ADDR_CH0CTL, 32'h0);
        chk("ch0_flag", 32'h1, 32'(rd[tocp_pkg::CH_FLAG]));
        wr(tocp_pkg::ADDR_CH0CTL, chc(tocp_pkg::MODE_UNBUF, 1'b1, tocp_pkg::ACT_CLEAR, 1'b1));
        // Smaller value written from the compare handler, already passed
        wait_for(1, 1'b0);
        wait_for(1, 1'b1);
        wr(tocp_pkg::ADDR_CH0VAL, 32'h0000_0040);
        pulse(hi, lo);
        chk("pwm_shorter", 32'd64, 32'(hi));
        // Larger value written just after overflow
        wr(tocp_pkg::ADDR_CH0VAL, 32'h0000_0090);
        pulse(hi, lo);
        chk("pwm_longer", 32'd144, 32'(hi));
        // Divide by two: every count lasts two bus clocks
        halt();
        wr(tocp_pkg::ADDR_MOD, 32'h0000_000F);
        wr(tocp_pkg::ADDR_CH0VAL, 32'h0000_0008);
        wr(tocp_pkg::ADDR_CTRL, 32'h1 << tocp_pkg::CTRL_PS_LSB);
        pulse(hi, lo);
        chk("ps_high", 32'd16, 32'(hi));
        chk("ps_period", 32'd32, 32'(hi + lo));
        // Pure compare actions, no overflow toggle
        for (int i = 0; i < 3; i++) begin
            halt();
            wr(tocp_pkg::ADDR_MOD, 32'h0000_003F);
            wr(tocp_pkg::ADDR_CH0VAL, 32'h0000_0010);
            wr(tocp_pkg::ADDR_CH0CTL, chc(tocp_pkg::MODE_UNBUF, 1'b0, acts[i], 1'b0));
            start();
            n = 0;
            prev = CH0_PIN_O;
            for (k = 0; k < 256; k++) begin
                @(posedge CLK_I);
                n += (CH0_PIN_O !== prev) ? 1 : 0;
                prev = CH0_PIN_O;
            end
            if (i == 2) begin
                chk("toggles", 32'd4, 32'(n));
            end else begin
                chk("act_level", 32'(i == 0), 32'(CH0_PIN_O));
            end
        end
        halt();
        wb(1'b0, tocp_pkg::ADDR_CNT, 32'h0);
        chk("cnt_cleared", 32'h0, rd);
        wr(tocp_pkg::ADDR_CH0CTL, 32'h0);
        wr(tocp_pkg::ADDR_CH1CTL, chc(tocp_pkg::MODE_UNBUF, 1'b0, tocp_pkg::ACT_SET, 1'b1));
        repeat (2) @(posedge CLK_I);
        chk("oe_mode00", 32'h2, {30'h0, CH1_PIN_OE_O, CH0_PIN_OE_O});
        // Channel 1 on its own: set on the first step of the count
        wr(tocp_pkg::ADDR_CH1VAL, 32'h0000_0001);
        start();
        repeat (4) @(posedge CLK_I);
        chk("ch1_set", 32'h1, 32'(CH1_PIN_O));
        chk("ch1_irq", 32'h1, 32'(CH1_IRQ_O));
        halt();
        // Linked pair: last written register pair wins at each overflow
        wr(tocp_pkg::ADDR_MOD, 32'h0000_00FF);
        wr(tocp_pkg::ADDR_CH1VAL, 32'h0000_00C0);
        wr(tocp_pkg::ADDR_CH0VAL, 32'h0000_0040);
        wr(tocp_pkg::ADDR_CH0CTL, chc(tocp_pkg::MODE_BUF, 1'b1, tocp_pkg::ACT_CLEAR, 1'b0));
        start();
        chk("oe_linked", 32'h1, {30'h0, CH1_PIN_OE_O, CH0_PIN_OE_O});
        pulse(hi, lo);
        chk("buf_first", 32'd64, 32'(hi));
        chk("ch1_irq_linked", 32'h0, 32'(CH1_IRQ_O));
        wr(tocp_pkg::ADDR_CH1VAL, 32'h0000_00C0);
        pulse(hi, lo);
        chk("buf_ch1", 32'd192, 32'(hi));
        chk("buf_period", 32'd256, 32'(hi + lo));
        wr(tocp_pkg::ADDR_CH0VAL, 32'h0000_0020);
        pulse(hi, lo);
        chk("buf_ch0_again", 32'd32, 32'(hi));
        chk("ch1_oe_linked", 32'h0, 32'(CH1_PIN_OE_O));
        results();
    end
endmodule
`default_nettype wire
